// >>> rtl/lie_defines.vh
// Constants for the display controller instruction executor
`ifndef LIE_DEFINES_VH
`define LIE_DEFINES_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LIE_CLK_PERIOD_NS   10
`define LIE_EXEC_TIME_NS    83400
`define LIE_BUSY_W          14

// ----------------------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------------------
`define LIE_ADDR_W          8
`define LIE_OFF_CMD         8'h00
`define LIE_OFF_STAT        8'h04
`define LIE_OFF_RAMD        8'h08

// Command register fields
`define LIE_CMD_RS          8

// Status register fields
`define LIE_ST_BUSY         0
`define LIE_ST_PWR          1
`define LIE_ST_DISP         2
`define LIE_ST_CURS         3
`define LIE_ST_BLINK        4
`define LIE_ST_INCR         5
`define LIE_ST_SHEN         6
`define LIE_ST_DEN          7
`define LIE_ST_OFF_LO       8
`define LIE_ST_AC_LO        16
`define LIE_ST_CON_LO       24

// ----------------------------------------------------------------------------
// Instruction bits
// ----------------------------------------------------------------------------
`define LIE_I_ADDR          7
`define LIE_I_CONTRAST      6
`define LIE_I_FUNC          5
`define LIE_I_SHIFT         4
`define LIE_I_DISPCTL       3
`define LIE_I_ENTRY         2
`define LIE_I_HOME          1
`define LIE_B_SC            3
`define LIE_B_RL            2
`define LIE_B_D             2
`define LIE_B_C             1
`define LIE_B_B             0
`define LIE_B_ID            1
`define LIE_B_S             0
`define LIE_B_PWR           0

// ----------------------------------------------------------------------------
// Address map and reset values
// ----------------------------------------------------------------------------
`define LIE_RAM_AW          7
`define LIE_RAM_DEPTH       128
`define LIE_LINE_LAST       4'hb
`define LIE_LINE_FIRST      4'h0
`define LIE_GLYPH_MASK      8'h1f
`define LIE_AC_RST          7'h00
`define LIE_OFF_RST         4'h0
`define LIE_OFF_LAST        4'hb
`define LIE_CON_RST         4'h0

`endif

// >>> rtl/lie_executor.v
// Instruction executor of a 12x4 character display controller with APB access
//
// Overview of operation
// - Highest set bit 4: cursor/display shift, select bit 3, direction bit 2, no RAM.
// - Cursor select: direction 0 decrements address, 1 increments it.
// - Display select: direction 0 shifts left, 1 right, cursor follows.
// - A display-only shift leaves the address counter unchanged.
// - Cursor past twelfth position of a line goes to next line start.
// - All lines shift together, rotating only within their own line.
// - Function set bit 0: 1 normal, 0 power-down with display forced off.
// - After power-down the display stays off until a display-on instruction.
// - Contrast instruction loads bits 3..0 into the 16-level contrast register.
// - Bit 7 set loads bits 6..0 into the address counter.
// - Map: lines 00-0B,10-1B,20-2B,30-3B; glyph 40-5F; icons 60-7F.
// - Data transfer writes its byte into the RAM that the address selects; at 40-7F only bits 4..0 are kept.
// - After each data write the address counter steps by entry mode.
// - Power-down blanks display, stops main oscillator, starts sub oscillator.
// - Power-down halts key scan and voltage generation, keeps RAM contents.
// - Increment flag 1 increments address; 0 decrements it.
// - Address set, cursor shift and data write are busy 83.4 us; display shift none.
`timescale 1ns/1ps
`include "lie_defines.vh"
module lie_executor #(
    parameter EXEC_CYCLES = `LIE_EXEC_TIME_NS / `LIE_CLK_PERIOD_NS
) (
    input  wire                   pclk,
    input  wire                   presetn,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`LIE_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    output wire [31:0]            prdata,
    output wire                   pready,
    output wire                   pslverr,
    output wire [6:0]             address_counter,
    output wire [3:0]             contrast_code,
    output wire [3:0]             shift_offset,
    output wire                   display_enable,
    output wire                   cursor_enable,
    output wire                   blink_enable,
    output wire                   main_osc_en,
    output wire                   sub_osc_en,
    output wire                   key_scan_en,
    output wire                   volt_gen_en,
    output wire                   busy
);

    // Load value cut to the counter width on purpose
    localparam [`LIE_BUSY_W-1:0] EXEC_LOAD = EXEC_CYCLES[`LIE_BUSY_W-1:0];
    localparam [`LIE_BUSY_W-1:0] BUSY_ONE  = {{(`LIE_BUSY_W-1){1'b0}}, 1'b1};

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------

    // True where an address holds real RAM
    function is_mapped;
        input [6:0] a;
        begin
            is_mapped = a[6] | (a[3:0] <= `LIE_LINE_LAST);
        end
    endfunction

    // Next address counter value, with line wrap inside the display area
    function [6:0] step_addr;
        input [6:0] a;
        input       up;
        begin
            if (a[6]) begin
                step_addr = up ? a + 7'h01 : a - 7'h01;
            end else if (up) begin
                if (a[3:0] == `LIE_LINE_LAST) begin
                    step_addr = {1'b0, a[5:4] + 2'h1, `LIE_LINE_FIRST};
                end else begin
                    step_addr = a + 7'h01;
                end
            end else begin
                if (a[3:0] == `LIE_LINE_FIRST) begin
                    step_addr = {1'b0, a[5:4] - 2'h1, `LIE_LINE_LAST};
                end else begin
                    step_addr = a - 7'h01;
                end
            end
        end
    endfunction

    // One display shift step; one offset for all lines keeps them in step
    function [3:0] shift_step;
        input [3:0] off;
        input       right;
        begin
            if (right) begin
                shift_step = (off == `LIE_OFF_RST) ? `LIE_OFF_LAST : off - 4'h1;
            end else begin
                shift_step = (off == `LIE_OFF_LAST) ? `LIE_OFF_RST : off + 4'h1;
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    reg [31:0]            prdata_q;
    reg                   pready_q;
    reg                   pslverr_q;
    reg                   wr_ok_q;
    reg [6:0]             ac_q;
    reg [6:0]             ac_d;
    reg [3:0]             con_q;
    reg [3:0]             con_d;
    reg [3:0]             off_q;
    reg [3:0]             off_d;
    reg                   pwr_q;
    reg                   pwr_d;
    reg                   sub_osc_q;
    reg                   disp_q;
    reg                   disp_d;
    reg                   den_q;
    reg                   curs_q;
    reg                   curs_d;
    reg                   blink_q;
    reg                   blink_d;
    reg                   incr_q;
    reg                   incr_d;
    reg                   shen_q;
    reg                   shen_d;
    reg [`LIE_BUSY_W-1:0] cnt_q;
    reg [`LIE_BUSY_W-1:0] cnt_d;
    reg                   busy_q;
    reg                   ram_we;
    reg [31:0]            rd_word;
    reg                   rd_err;
    reg                   wr_ok_d;

    wire [7:0]            ram_rdata;
    wire [7:0]            db      = pwdata[7:0];
    wire                  rs      = pwdata[`LIE_CMD_RS];
    wire                  acc     = psel & penable;
    wire                  take    = acc & pready_q;
    wire                  cmd_go  = take & wr_ok_q;
    wire [7:0]            ram_wd  = ac_q[6] ? (db & `LIE_GLYPH_MASK) : db;

    // ------------------------------------------------------------------------
    // Shared RAM, addressed by the address counter
    // ------------------------------------------------------------------------
    lie_ram #(
        .DEPTH (`LIE_RAM_DEPTH),
        .AW    (`LIE_RAM_AW),
        .DW    (8)
    ) u_ram (
        .clk     (pclk),
        .we      (ram_we),
        .addr    (ac_q),
        .wdata   (ram_wd),
        .rdata_q (ram_rdata)
    );

    // ------------------------------------------------------------------------
    // APB read mux and error decode, taken in the first access cycle
    // ------------------------------------------------------------------------
    always @* begin
        rd_word = 32'h0000_0000;
        rd_err  = 1'b0;
        wr_ok_d = 1'b0;
        if (pwrite) begin
            if (paddr == `LIE_OFF_CMD) begin
                wr_ok_d = ~busy_q;            // Busy refuses the command
                rd_err  = busy_q;
            end else begin
                rd_err  = 1'b1;               // Read-only or unmapped
            end
        end else begin
            case (paddr)
                `LIE_OFF_CMD: begin
                    rd_word = 32'h0000_0000;
                end
                `LIE_OFF_STAT: begin
                    rd_word[`LIE_ST_BUSY]             = busy_q;
                    rd_word[`LIE_ST_PWR]              = pwr_q;
                    rd_word[`LIE_ST_DISP]             = disp_q;
                    rd_word[`LIE_ST_CURS]             = curs_q;
                    rd_word[`LIE_ST_BLINK]            = blink_q;
                    rd_word[`LIE_ST_INCR]             = incr_q;
                    rd_word[`LIE_ST_SHEN]             = shen_q;
                    rd_word[`LIE_ST_DEN]              = den_q;
                    rd_word[`LIE_ST_OFF_LO+3:`LIE_ST_OFF_LO] = off_q;
                    rd_word[`LIE_ST_AC_LO+6:`LIE_ST_AC_LO]   = ac_q;
                    rd_word[`LIE_ST_CON_LO+3:`LIE_ST_CON_LO] = con_q;
                end
                `LIE_OFF_RAMD: begin
                    rd_word[7:0] = ram_rdata;
                end
                default: begin
                    rd_err = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Instruction decode and execution
    // ------------------------------------------------------------------------
    always @* begin
        ac_d    = ac_q;
        con_d   = con_q;
        off_d   = off_q;
        pwr_d   = pwr_q;
        disp_d  = disp_q;
        curs_d  = curs_q;
        blink_d = blink_q;
        incr_d  = incr_q;
        shen_d  = shen_q;
        ram_we  = 1'b0;
        cnt_d   = (cnt_q != {`LIE_BUSY_W{1'b0}}) ? cnt_q - BUSY_ONE : cnt_q;
        if (cmd_go) begin
            if (rs) begin
                // Data write into the RAM the address counter selects
                ram_we = is_mapped(ac_q);
                ac_d   = step_addr(ac_q, incr_q);
                cnt_d  = EXEC_LOAD;
                if (shen_q && !ac_q[6]) begin
                    off_d = shift_step(off_q, ~incr_q);
                end
            end else if (db[`LIE_I_ADDR]) begin
                ac_d  = db[6:0];
                cnt_d = EXEC_LOAD;
            end else if (db[`LIE_I_CONTRAST]) begin
                con_d = db[3:0];
            end else if (db[`LIE_I_FUNC]) begin
                // Accepted in either power state
                pwr_d = db[`LIE_B_PWR];
                if (!db[`LIE_B_PWR]) begin
                    disp_d = 1'b0;
                end
            end else if (db[`LIE_I_SHIFT]) begin
                if (db[`LIE_B_SC]) begin
                    off_d = shift_step(off_q, db[`LIE_B_RL]);
                end else begin
                    ac_d  = step_addr(ac_q, db[`LIE_B_RL]);
                    cnt_d = EXEC_LOAD;
                end
            end else if (db[`LIE_I_DISPCTL]) begin
                disp_d  = db[`LIE_B_D];
                curs_d  = db[`LIE_B_C];
                blink_d = db[`LIE_B_B];
            end else if (db[`LIE_I_ENTRY]) begin
                incr_d = db[`LIE_B_ID];
                shen_d = db[`LIE_B_S];
            end else if (db[`LIE_I_HOME]) begin
                ac_d  = `LIE_AC_RST;
                off_d = `LIE_OFF_RST;
                cnt_d = EXEC_LOAD;
            end
        end
    end

    // ------------------------------------------------------------------------
    // APB handshake: one wait cycle, then completion
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            wr_ok_q   <= 1'b0;
        end else if (acc && !pready_q) begin
            prdata_q  <= rd_word;
            pready_q  <= 1'b1;
            pslverr_q <= rd_err;
            wr_ok_q   <= wr_ok_d;
        end else begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            wr_ok_q   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Control state and registered outputs
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ac_q      <= `LIE_AC_RST;
            con_q     <= `LIE_CON_RST;
            off_q     <= `LIE_OFF_RST;
            pwr_q     <= 1'b1;
            sub_osc_q <= 1'b0;
            disp_q    <= 1'b0;
            den_q     <= 1'b0;
            curs_q    <= 1'b0;
            blink_q   <= 1'b0;
            incr_q    <= 1'b1;
            shen_q    <= 1'b0;
            cnt_q     <= {`LIE_BUSY_W{1'b0}};
            busy_q    <= 1'b0;
        end else begin
            ac_q      <= ac_d;
            con_q     <= con_d;
            off_q     <= off_d;
            pwr_q     <= pwr_d;
            sub_osc_q <= ~pwr_d;
            disp_q    <= disp_d;
            den_q     <= disp_d & pwr_d;
            curs_q    <= curs_d;
            blink_q   <= blink_d;
            incr_q    <= incr_d;
            shen_q    <= shen_d;
            cnt_q     <= cnt_d;
            busy_q    <= (cnt_d != {`LIE_BUSY_W{1'b0}});
        end
    end

    // ------------------------------------------------------------------------
    // Output wiring, each straight from a flip-flop
    // ------------------------------------------------------------------------
    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign address_counter = ac_q;
    assign contrast_code   = con_q;
    assign shift_offset    = off_q;
    assign display_enable  = den_q;
    assign cursor_enable   = curs_q;
    assign blink_enable    = blink_q;
    assign main_osc_en     = pwr_q;
    assign sub_osc_en      = sub_osc_q;
    assign key_scan_en     = pwr_q;
    assign volt_gen_en     = pwr_q;

    assign busy            = busy_q;

endmodule // lie_executor

// >>> rtl/lie_ram.v
// Shared display, glyph and icon RAM with registered read data
`timescale 1ns/1ps
module lie_ram #(
    parameter DEPTH = 128,
    parameter AW    = 7,
    parameter DW    = 8
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata_q
);

    reg [DW-1:0] mem [0:DEPTH-1];

    // Read first port, read data one cycle behind the address
    always @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end

endmodule // lie_ram

// >>> testbench/lie_apb_host.sv
// APB host model issuing transfers to the executor
`timescale 1ns/1ps
module lie_apb_host (
    input  wire         pclk,
    input  wire  [31:0] prdata,
    input  wire         pready,
    input  wire         pslverr,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [7:0]  paddr,
    output logic [31:0] pwdata
);
    // Idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end
    // One transfer; address and data lines are inverted on release so stale values cannot pass
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule // lie_apb_host

// >>> testbench/lie_executor_assertions.sv
// Port checks for the instruction executor
`timescale 1ns/1ps
module lie_executor_assertions #(
    parameter EXEC_CYCLES = 4
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [6:0]  address_counter,
    input wire [3:0]  contrast_code,
    input wire [3:0]  shift_offset,
    input wire        display_enable,
    input wire        cursor_enable,
    input wire        blink_enable,
    input wire        main_osc_en,
    input wire        sub_osc_en,
    input wire        key_scan_en,
    input wire        volt_gen_en,
    input wire        busy
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Accepted command write and accepted instruction
    wire ok  = psel & penable & pready & pwrite & ~pslverr & (paddr == 8'h00);
    wire ins = ok & ~pwdata[8];
    reg        incr_q;
    reg [15:0] run_q;
    // Entry direction copy and busy run length
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            incr_q <= 1'b1;
            run_q  <= 16'h0000;
        end else begin
            if (ins && pwdata[7:2] == 6'h01)
                incr_q <= pwdata[1];
            run_q <= busy ? run_q + 16'h0001 : 16'h0000;
        end
    end
    // Address step, wrapping line to line below the glyph area
    function automatic [6:0] f_step(input [6:0] a, input up);
        if (a[6] || a[3:0] > 4'hb)
            f_step = up ? a + 7'h01 : a - 7'h01;
        else if (up)
            f_step = (a[3:0] == 4'hb) ? {1'b0, a[5:4] + 2'h1, 4'h0} : a + 7'h01;
        else
            f_step = (a[3:0] == 4'h0) ? {1'b0, a[5:4] - 2'h1, 4'hb} : a - 7'h01;
    endfunction
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_off; ins && pwdata[7:3] == 5'h03; endsequence
    sequence s_wake; !main_osc_en ##0 ins && pwdata[7:5] == 3'h1 && pwdata[0]; endsequence
    property p_off_l; s_off ##0 !pwdata[2] |=> shift_offset ==
        (($past(shift_offset) == 4'hb) ? 4'h0 : $past(shift_offset) + 4'h1); endproperty
    a_off_l: assert property (p_off_l) else $error("left shift offset wrong");
    property p_off_r; s_off ##0 pwdata[2] |=> shift_offset ==
        (($past(shift_offset) == 4'h0) ? 4'hb : $past(shift_offset) - 4'h1); endproperty
    a_off_r: assert property (p_off_r) else $error("right shift offset wrong");
    property p_off_ac; s_off |=> $stable(address_counter) && !busy; endproperty
    a_off_ac: assert property (p_off_ac) else $error("display shift moved address");
    property p_cur; ins && pwdata[7:3] == 5'h02 |=> busy &&
        address_counter == f_step($past(address_counter), $past(pwdata[2])); endproperty
    a_cur: assert property (p_cur) else $error("cursor step wrong");
    property p_aset; ins && pwdata[7] |=> address_counter == $past(pwdata[6:0]) && busy;
    endproperty
    a_aset: assert property (p_aset) else $error("address set wrong");
    property p_con; ins && pwdata[7:6] == 2'h1 |=> contrast_code == $past(pwdata[3:0]);
    endproperty
    a_con: assert property (p_con) else $error("contrast load wrong");
    property p_pd; ins && pwdata[7:5] == 3'h1 && !pwdata[0] |=> !display_enable &&
        !main_osc_en && sub_osc_en && !key_scan_en && !volt_gen_en; endproperty
    a_pd: assert property (p_pd) else $error("power-down state wrong");
    property p_wake; s_wake |=> main_osc_en && !sub_osc_en && !display_enable; endproperty
    a_wake: assert property (p_wake) else $error("wake state wrong");
    property p_dw; ok && pwdata[8] |=> busy &&
        address_counter == f_step($past(address_counter), incr_q); endproperty
    a_dw: assert property (p_dw) else $error("data write step wrong");
    property p_busy; $fell(busy) |-> run_q == EXEC_CYCLES; endproperty
    a_busy: assert property (p_busy) else $error("busy length wrong");
endmodule // lie_executor_assertions

bind lie_executor lie_executor_assertions #(.EXEC_CYCLES(EXEC_CYCLES)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .address_counter(address_counter), .contrast_code(contrast_code),
    .shift_offset(shift_offset), .display_enable(display_enable),
    .cursor_enable(cursor_enable), .blink_enable(blink_enable), .main_osc_en(main_osc_en),
    .sub_osc_en(sub_osc_en), .key_scan_en(key_scan_en), .volt_gen_en(volt_gen_en),
    .busy(busy));

// >>> testbench/lie_executor_tb.sv
// Self-checking bench for the instruction executor
`timescale 1ns/1ps
module lie_executor_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [6:0]  address_counter;
    logic [3:0]  contrast_code, shift_offset;
    logic        display_enable, cursor_enable, blink_enable, busy;
    logic        main_osc_en, sub_osc_en, key_scan_en, volt_gen_en;
    int          n_mismatch, compares, i;
    logic [6:0]  ram_a [0:2] = '{7'h23, 7'h45, 7'h6f};
    logic [7:0]  ram_d [0:2] = '{8'h5a, 8'h1a, 8'h1a};
    // Rows: command, address, offset, contrast; bring-up sequence first
    logic [27:0] rows [0:21] = '{28'h021_00_00, 28'h00c_00_00, 28'h006_00_00, 28'h08b_0b_00,
        28'h014_10_00, 28'h010_0b_00, 28'h018_0b_10, 28'h01c_0b_00, 28'h01c_0b_b0,
        28'h018_0b_00, 28'h04f_0b_0f, 28'h045_0b_05, 28'h040_0b_00, 28'h0bb_3b_00,
        28'h141_00_00, 28'h004_00_00, 28'h141_3b_00, 28'h0c0_40_00, 28'h155_3f_00,
        28'h006_3f_00, 28'h0ff_7f_00, 28'h1aa_00_00};

    always #5 pclk = ~pclk;

    lie_executor #(.EXEC_CYCLES(4)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .address_counter(address_counter), .contrast_code(contrast_code),
        .shift_offset(shift_offset), .display_enable(display_enable),
        .cursor_enable(cursor_enable), .blink_enable(blink_enable),
        .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en), .key_scan_en(key_scan_en),
        .volt_gen_en(volt_gen_en), .busy(busy));
    lie_apb_host host_u (
        .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask
    // Instruction or data write, then wait out busy
    task automatic cmd(input logic [8:0] c);
        int k;
        host_u.xfer(1'b1, 8'h00, {23'h0, c}, r, e);
        @(posedge pclk);
        for (k = 0; k < 50 && busy !== 1'b0; k++) @(posedge pclk);
    endtask
    task test_done;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    // Main test sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("reset", 32'h4, {address_counter, contrast_code, shift_offset, display_enable,
            main_osc_en, sub_osc_en, busy});
        $display("reset test done");
        for (i = 0; i < 22; i++) begin
            cmd(rows[i][24:16]);
            chk("ac", rows[i][15:8], address_counter);
            chk("off", rows[i][7:4], shift_offset);
            chk("con", rows[i][3:0], contrast_code);
        end
        chk("disp", 1, display_enable);
        $display("table test done");
        host_u.xfer(1'b1, 8'h00, 32'h0000_0018, r, e);
        @(posedge pclk);
        chk("shift_busy", 0, {e, busy});
        host_u.xfer(1'b1, 8'h00, 32'h0000_0085, r, e);
        host_u.xfer(1'b1, 8'h00, 32'h0000_0047, r, e);
        chk("refused", 1, e);
        cmd(9'h000);
        chk("con_kept", 0, contrast_code);
        $display("busy test done");
        for (i = 0; i < 3; i++) begin
            cmd({2'b01, ram_a[i]});
            cmd(9'h15a);
            cmd({2'b01, ram_a[i]});
            host_u.xfer(1'b0, 8'h08, 32'h0, r, e);
            chk("ramd", ram_d[i], r[7:0]);
        end
        $display("ram test done");
        cmd(9'h020);
        chk("pd", 32'h4, {display_enable, main_osc_en, sub_osc_en, key_scan_en,
            volt_gen_en});
        cmd(9'h0a3);
        host_u.xfer(1'b0, 8'h08, 32'h0, r, e);
        chk("kept", 32'h5a, r[7:0]);
        cmd(9'h021);
        chk("wake", 32'hb, {display_enable, main_osc_en, sub_osc_en, key_scan_en,
            volt_gen_en});
        cmd(9'h00f);
        chk("on", 32'h7, {display_enable, cursor_enable, blink_enable});
        // Status word: AC 23, offset 1, all flags but busy and shift-on-write set
        host_u.xfer(1'b0, 8'h04, 32'h0, r, e);
        chk("stat", 32'h0023_01be, r);
        cmd(9'h002);
        chk("home", 0, {address_counter, shift_offset});
        cmd(9'h0b5);
        cmd(9'h04a);
        $display("power test done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("rst2", 0, {address_counter, display_enable, contrast_code});
        presetn <= 1'b1;
        @(posedge pclk);
        chk("rel", 0, {pready, pslverr, busy});
        $display("second reset test done");
        test_done;
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        test_done;
    end
endmodule // lie_executor_tb
